// ==== common/phy_timing_defines.vh ====
`ifndef PHY_TIMING_DEFINES_VH
`define PHY_TIMING_DEFINES_VH

// ----------------------------------------
// register indices (word addresses)
// ----------------------------------------
`define ADDR_PACKET_CTRL 3'h0
`define ADDR_BUS_RESET_RESULT 3'h1
`define ADDR_CONN_TIMEOUT 3'h2
`define ADDR_RESET_RESPONSE 3'h3
`define ADDR_ARB_WATCHDOG 3'h4
`define ADDR_ROOT_FORCE 3'h5
`define ADDR_BIAS_EXCHANGE 3'h6
`define ADDR_BIAS_DEBOUNCE 3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define AUTO_APPLY_BIT 0
`define TIMER_EN_BIT 31
`define LONG_FIELD_HI 24
`define LONG_FIELD_LO 11
`define SHORT_FIELD_HI 15
`define SHORT_FIELD_LO 0
`define ROOT_NODE_HI 13
`define ROOT_NODE_LO 8
`define RM_NODE_HI 5
`define RM_NODE_LO 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_AUTO_APPLY 1'h0
`define RST_TIMER_EN 1'h1
`define RST_RM_NODE 6'h3f
`define RST_ROOT_NODE 6'h00
`define RST_CONN_TIMEOUT 14'h0a80
`define RST_RESET_RESPONSE 14'h0280
`define RST_ARB_WATCHDOG 16'h2710
`define RST_ROOT_FORCE 16'h0f8d
`define RST_BIAS_EXCHANGE 14'h002b
`define RST_BIAS_DEBOUNCE 16'h0410

// ----------------------------------------
// timing: 125 us slow tick, 40 ns fast tick, 50 ns clock
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define SLOW_TICK_NS 125000
`define FAST_TICK_NS 40
`define SLOW_TICK_CYCLES (`SLOW_TICK_NS / `CLK_PERIOD_NS)
// last divider count, sized to the 12-bit divider (2500 - 1)
`define SLOW_TICK_LAST 12'h9c3
// a 40 ns tick is shorter than the clock, so it rounds up to one cycle
`define FAST_TICK_CYCLES (((`FAST_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`endif

// ==== logic/interval_timer.v ====
`include "phy_timing_defines.vh"

// one programmable interval timer: counts ticks after a start pulse
module interval_timer (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // control
  input wire enable_i,
  input wire tick_i,
  input wire start_i,
  input wire [15:0] limit_i,
  // status
  output reg running_o,
  output reg expired_o
);

  reg [15:0] count_reg;

  always @(posedge clock_i) begin
    if (rst_i) begin
      count_reg <= 16'h0000;
      running_o <= 1'b0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= 1'b0;
      if (start_i) begin
        count_reg <= 16'h0000;
        running_o <= enable_i;
      end else if (running_o && !enable_i) begin
        // disabled timer stops counting and never expires
        running_o <= 1'b0;
      end else if (running_o && tick_i) begin
        if (count_reg + 16'h0001 >= limit_i) begin
          running_o <= 1'b0;
          expired_o <= 1'b1;
        end else begin
          count_reg <= count_reg + 16'h0001;
        end
      end
    end
  end

endmodule

// ==== logic/phy_timing_option_registers.v ====
`include "phy_timing_defines.vh"

// What this block does
// - auto bit applies config packet fields
// - root node number read at 13:8
// - resource manager node at 5:0, reset 3Fh
// - connection timeout is field times 125us
// - connection enable clear stops counting
// - reset response delay field times 125us
// - reset delay enable clear stops counting
// - overlong arbitration state sets timeout bit
// - arbitration limit is field times one 50ns clock (40ns tick rounded up)
// - arbitration enable clear stops counting
// - force-root wait after holdoff bit set
// - force-root enable clear stops counting
// - bias exchange field times 125us
// - bias exchange times three spans
// - bias exchange enable clear stops counting
// - bias debounce before setting bias bit
// - bias debounce enable clear stops counting
module phy_timing_option_registers (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // register port
  input wire reg_sel_i,
  input wire reg_write_i,
  input wire [2:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  // phy configuration packet and bus reset results
  input wire config_pkt_valid_i,
  input wire [5:0] config_gap_count_i,
  input wire config_root_holdoff_i,
  input wire tree_resolved_i,
  input wire [5:0] root_node_number_i,
  input wire [5:0] resource_manager_node_i,
  // phy events that start timers, and the cable bias level
  input wire conn_start_i,
  input wire bus_reset_seen_i,
  input wire arb_state_change_i,
  input wire root_holdoff_set_i,
  input wire suspend_start_i,
  input wire peer_bias_seen_i,
  input wire resume_start_i,
  input wire cable_bias_signal_i,
  // phy register fields
  output reg [5:0] gap_count_o,
  output reg root_holdoff_bit_o,
  output reg arb_timeout_o,
  output reg bias_bit_o,
  // timer expiry pulses
  output wire conn_timeout_o,
  output wire reset_response_o,
  output wire tree_id_start_o,
  output wire bias_exchange_done_o,
  output wire bias_debounce_done_o
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg phy_config_auto_apply_reg;
  reg [5:0] root_node_number_reg;
  reg [5:0] resource_manager_node_reg;
  reg conn_timer_enable_reg;
  reg [13:0] conn_timeout_reg;
  reg reset_delay_timer_enable_reg;
  reg [13:0] reset_response_reg;
  reg arb_state_timer_enable_reg;
  reg [15:0] arb_watchdog_reg;
  reg root_force_timer_enable_reg;
  reg [15:0] root_force_reg;
  reg bias_exchange_enable_reg;
  reg [13:0] bias_exchange_reg;
  reg bias_debounce_enable_reg;
  reg [15:0] bias_debounce_reg;
  reg [11:0] slow_div_reg;
  reg slow_tick_reg;

  wire wr_en;
  wire fast_tick;
  wire arb_expired;
  wire debounce_expired;

  assign wr_en = reg_sel_i & reg_write_i;
  assign fast_tick = 1'b1;

  function [31:0] long_word;
    input en;
    input [13:0] val;
    begin
      long_word = {en, 6'h00, val, 11'h000};
    end
  endfunction

  function [31:0] short_word;
    input en;
    input [15:0] val;
    begin
      short_word = {en, 15'h0000, val};
    end
  endfunction

  // ----------------------------------------
  // 125 us tick divider
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      slow_div_reg <= 12'h000;
      slow_tick_reg <= 1'b0;
    end else if (slow_div_reg == `SLOW_TICK_LAST) begin
      slow_div_reg <= 12'h000;
      slow_tick_reg <= 1'b1;
    end else begin
      slow_div_reg <= slow_div_reg + 12'h001;
      slow_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // software writes
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      phy_config_auto_apply_reg <= `RST_AUTO_APPLY;
      conn_timer_enable_reg <= `RST_TIMER_EN;
      conn_timeout_reg <= `RST_CONN_TIMEOUT;
      reset_delay_timer_enable_reg <= `RST_TIMER_EN;
      reset_response_reg <= `RST_RESET_RESPONSE;
      arb_state_timer_enable_reg <= `RST_TIMER_EN;
      arb_watchdog_reg <= `RST_ARB_WATCHDOG;
      root_force_timer_enable_reg <= `RST_TIMER_EN;
      root_force_reg <= `RST_ROOT_FORCE;
      bias_exchange_enable_reg <= `RST_TIMER_EN;
      bias_exchange_reg <= `RST_BIAS_EXCHANGE;
      bias_debounce_enable_reg <= `RST_TIMER_EN;
      bias_debounce_reg <= `RST_BIAS_DEBOUNCE;
    end else if (wr_en) begin
      case (reg_addr_i)
        `ADDR_PACKET_CTRL: begin
          phy_config_auto_apply_reg <= reg_wdata_i[`AUTO_APPLY_BIT];
        end
        `ADDR_CONN_TIMEOUT: begin
          conn_timer_enable_reg <= reg_wdata_i[`TIMER_EN_BIT];
          conn_timeout_reg <= reg_wdata_i[`LONG_FIELD_HI:`LONG_FIELD_LO];
        end
        `ADDR_RESET_RESPONSE: begin
          reset_delay_timer_enable_reg <= reg_wdata_i[`TIMER_EN_BIT];
          reset_response_reg <= reg_wdata_i[`LONG_FIELD_HI:`LONG_FIELD_LO];
        end
        `ADDR_ARB_WATCHDOG: begin
          arb_state_timer_enable_reg <= reg_wdata_i[`TIMER_EN_BIT];
          arb_watchdog_reg <= reg_wdata_i[`SHORT_FIELD_HI:`SHORT_FIELD_LO];
        end
        `ADDR_ROOT_FORCE: begin
          root_force_timer_enable_reg <= reg_wdata_i[`TIMER_EN_BIT];
          root_force_reg <= reg_wdata_i[`SHORT_FIELD_HI:`SHORT_FIELD_LO];
        end
        `ADDR_BIAS_EXCHANGE: begin
          bias_exchange_enable_reg <= reg_wdata_i[`TIMER_EN_BIT];
          bias_exchange_reg <= reg_wdata_i[`LONG_FIELD_HI:`LONG_FIELD_LO];
        end
        `ADDR_BIAS_DEBOUNCE: begin
          bias_debounce_enable_reg <= reg_wdata_i[`TIMER_EN_BIT];
          bias_debounce_reg <= reg_wdata_i[`SHORT_FIELD_HI:`SHORT_FIELD_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux (registered data)
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_sel_i && !reg_write_i) begin
      case (reg_addr_i)
        `ADDR_PACKET_CTRL: reg_rdata_o <= {31'h00000000, phy_config_auto_apply_reg};
        `ADDR_BUS_RESET_RESULT: begin
          reg_rdata_o <= {18'h00000, root_node_number_reg, 2'h0, resource_manager_node_reg};
        end
        `ADDR_CONN_TIMEOUT: reg_rdata_o <= long_word(conn_timer_enable_reg, conn_timeout_reg);
        `ADDR_RESET_RESPONSE: begin
          reg_rdata_o <= long_word(reset_delay_timer_enable_reg, reset_response_reg);
        end
        `ADDR_ARB_WATCHDOG: begin
          reg_rdata_o <= short_word(arb_state_timer_enable_reg, arb_watchdog_reg);
        end
        `ADDR_ROOT_FORCE: reg_rdata_o <= short_word(root_force_timer_enable_reg, root_force_reg);
        `ADDR_BIAS_EXCHANGE: begin
          reg_rdata_o <= long_word(bias_exchange_enable_reg, bias_exchange_reg);
        end
        `ADDR_BIAS_DEBOUNCE: begin
          reg_rdata_o <= short_word(bias_debounce_enable_reg, bias_debounce_reg);
        end
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // bus reset results and phy register fields
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      // root number is undefined after reset; zero keeps it deterministic
      root_node_number_reg <= `RST_ROOT_NODE;
      resource_manager_node_reg <= `RST_RM_NODE;
      gap_count_o <= 6'h3f;
      root_holdoff_bit_o <= 1'b0;
    end else begin
      if (tree_resolved_i) begin
        root_node_number_reg <= root_node_number_i;
        resource_manager_node_reg <= resource_manager_node_i;
      end
      // apply config packet only when enabled
      if (config_pkt_valid_i && phy_config_auto_apply_reg) begin
        gap_count_o <= config_gap_count_i;
        root_holdoff_bit_o <= config_root_holdoff_i;
      end
    end
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  // connection timer gated by enable
  interval_timer conn_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(conn_timer_enable_reg),
    .tick_i(slow_tick_reg),
    .start_i(conn_start_i),
    .limit_i({2'h0, conn_timeout_reg}),
    .running_o(),
    .expired_o(conn_timeout_o)
  );

  interval_timer reset_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(reset_delay_timer_enable_reg),
    .tick_i(slow_tick_reg),
    .start_i(bus_reset_seen_i),
    .limit_i({2'h0, reset_response_reg}),
    .running_o(),
    .expired_o(reset_response_o)
  );

  // arbitration watchdog, restarted on every state change
  interval_timer arb_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(arb_state_timer_enable_reg),
    .tick_i(fast_tick),
    .start_i(arb_state_change_i),
    .limit_i(arb_watchdog_reg),
    .running_o(),
    .expired_o(arb_expired)
  );

  interval_timer root_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(root_force_timer_enable_reg),
    .tick_i(fast_tick),
    .start_i(root_holdoff_set_i),
    .limit_i(root_force_reg),
    .running_o(),
    .expired_o(tree_id_start_o)
  );

  // any of three spans restarts it
  interval_timer bias_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(bias_exchange_enable_reg),
    .tick_i(slow_tick_reg),
    .start_i(suspend_start_i | peer_bias_seen_i | resume_start_i),
    .limit_i({2'h0, bias_exchange_reg}),
    .running_o(),
    .expired_o(bias_exchange_done_o)
  );

  interval_timer debounce_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(bias_debounce_enable_reg),
    .tick_i(fast_tick),
    .start_i(peer_bias_seen_i),
    .limit_i(bias_debounce_reg),
    .running_o(),
    .expired_o(debounce_expired)
  );

  assign bias_debounce_done_o = debounce_expired;

  // ----------------------------------------
  // timeout and bias bits
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      arb_timeout_o <= 1'b0;
      bias_bit_o <= 1'b0;
    end else begin
      // set on overlong state, cleared by a later state change
      if (arb_expired) begin
        arb_timeout_o <= 1'b1;
      end else if (arb_state_change_i) begin
        arb_timeout_o <= 1'b0;
      end
      // bias bit follows the filtered peer bias
      if (debounce_expired && cable_bias_signal_i) begin
        bias_bit_o <= 1'b1;
      end else if (!cable_bias_signal_i) begin
        bias_bit_o <= 1'b0;
      end
    end
  end

endmodule

// ==== test/phy_timing_chk.sv ====
// ----------------------------------------
// port checker
// ----------------------------------------
module phy_timing_chk (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_sel_i,
  input wire logic reg_write_i,
  input wire logic [31:0] reg_rdata_o,
  // phy side
  input wire logic config_pkt_valid_i,
  input wire logic cable_bias_signal_i,
  input wire logic [5:0] gap_count_o,
  input wire logic bias_bit_o,
  input wire logic conn_timeout_o,
  input wire logic reset_response_o,
  input wire logic tree_id_start_o,
  input wire logic bias_exchange_done_o,
  input wire logic bias_debounce_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // an expiry is a single-cycle pulse
  sequence s_drop(x);
    ##1 !x;
  endsequence
  property p_rdata_hold;
    !(reg_sel_i && !reg_write_i) |=> $stable(reg_rdata_o);
  endproperty
  // the update may land one cycle after the packet, so both cycles are excluded
  property p_gap_hold;
    !config_pkt_valid_i && !$past(config_pkt_valid_i) |=> $stable(gap_count_o);
  endproperty
  property p_bias_drop;
    !cable_bias_signal_i |=> !bias_bit_o;
  endproperty
  property p_bias_rise;
    $rose(bias_bit_o) |-> $past(cable_bias_signal_i);
  endproperty
  property p_conn_pulse;
    conn_timeout_o |-> s_drop(conn_timeout_o);
  endproperty
  property p_resp_pulse;
    reset_response_o |-> s_drop(reset_response_o);
  endproperty
  property p_tree_pulse;
    tree_id_start_o |-> s_drop(tree_id_start_o);
  endproperty
  property p_exch_pulse;
    bias_exchange_done_o |-> s_drop(bias_exchange_done_o);
  endproperty
  property p_deb_pulse;
    bias_debounce_done_o |-> s_drop(bias_debounce_done_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  a_gap_hold: assert property (p_gap_hold) else $error("gap count moved without packet");
  a_bias_drop: assert property (p_bias_drop) else $error("bias bit kept after bias loss");
  a_bias_rise: assert property (p_bias_rise) else $error("bias bit set without bias");
  a_conn_pulse: assert property (p_conn_pulse) else $error("connection pulse too long");
  a_resp_pulse: assert property (p_resp_pulse) else $error("response pulse too long");
  a_tree_pulse: assert property (p_tree_pulse) else $error("tree start pulse too long");
  a_exch_pulse: assert property (p_exch_pulse) else $error("exchange pulse too long");
  a_deb_pulse: assert property (p_deb_pulse) else $error("debounce pulse too long");
endmodule

bind phy_timing_option_registers phy_timing_chk u_chk (.clock_i, .rst_i, .reg_sel_i,
  .reg_write_i, .reg_rdata_o, .config_pkt_valid_i, .cable_bias_signal_i, .gap_count_o,
  .bias_bit_o, .conn_timeout_o, .reset_response_o, .tree_id_start_o, .bias_exchange_done_o,
  .bias_debounce_done_o);

// ==== test/tb_top.sv ====
`include "phy_timing_defines.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0;
  logic rst_i = 1;
  logic reg_sel_i = 0;
  logic reg_write_i = 0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic cfg_v = 0;
  logic [5:0] cfg_gap = 6'h00;
  logic cfg_rhb = 0;
  logic tree_v = 0;
  logic [5:0] root_n = 6'h00;
  logic [5:0] rm_n = 6'h00;
  logic [6:0] ev = 7'h00;
  logic bias_in = 0;
  logic [31:0] reg_rdata_o;
  logic [5:0] gap_count_o;
  logic rhb_o;
  logic bias_bit_o;
  logic [5:0] done;
  logic rd_last = 0;
  logic [31:0] exp_q[$];
  int failures = 0;
  int check_count = 0;
  int seed = 32'hbf01;
  logic [31:0] rst_tab [2:7] = '{{1'b1, 6'h0, `RST_CONN_TIMEOUT, 11'h0},
    {1'b1, 6'h0, `RST_RESET_RESPONSE, 11'h0}, {1'b1, 15'h0, `RST_ARB_WATCHDOG},
    {1'b1, 15'h0, `RST_ROOT_FORCE}, {1'b1, 6'h0, `RST_BIAS_EXCHANGE, 11'h0},
    {1'b1, 15'h0, `RST_BIAS_DEBOUNCE}};

  phy_timing_option_registers uut (.clock_i(clock_i), .rst_i(rst_i), .reg_sel_i(reg_sel_i),
    .reg_write_i(reg_write_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .config_pkt_valid_i(cfg_v), .config_gap_count_i(cfg_gap),
    .config_root_holdoff_i(cfg_rhb), .tree_resolved_i(tree_v), .root_node_number_i(root_n),
    .resource_manager_node_i(rm_n), .arb_state_change_i(ev[0]), .root_holdoff_set_i(ev[1]),
    .peer_bias_seen_i(ev[2]), .conn_start_i(ev[3]), .bus_reset_seen_i(ev[4]),
    .suspend_start_i(ev[5]), .resume_start_i(ev[6]), .cable_bias_signal_i(bias_in),
    .gap_count_o(gap_count_o), .root_holdoff_bit_o(rhb_o), .arb_timeout_o(done[0]),
    .bias_bit_o(bias_bit_o), .conn_timeout_o(done[3]), .reset_response_o(done[4]),
    .tree_id_start_o(done[1]), .bias_exchange_done_o(done[5]), .bias_debounce_done_o(done[2]));

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    check_count++;
    if (n < lo || n > hi) begin
      failures++;
      $display("ERROR %0t delay %0d cycles expected %0d..%0d", $time, n, lo, hi);
    end
  endtask

  task automatic acc(input logic wr, input logic [2:0] a, input logic [31:0] d);
    reg_sel_i <= 1;
    reg_write_i <= wr;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_sel_i <= 0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(0, a, 32'h0);
  endtask

  // pulse a start input, count edges until the matching result shows
  task automatic fire(input int i, input int lo, input int hi);
    int n = 0;
    ev[i] <= 1;
    @(posedge clock_i);
    ev[i] <= 0;
    #1;
    while (done[(i > 5) ? 5 : i] !== 1'b1 && n < 6000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk_rng(n, lo, hi);
    @(posedge clock_i);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    rd_last <= reg_sel_i && !reg_write_i && !rst_i;
    if (rd_last) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("ERROR %0t read with no expectation", $time);
      end else begin
        chk(reg_rdata_o, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clock_i);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [2:0] a;
    logic [31:0] d;
    logic [5:0] g;
    int n;
    repeat (4) @(posedge clock_i);
    rst_i <= 0;
    bias_in <= 1;
    rd(3'h0, 32'h00000000);
    rd(3'h1, 32'h0000003f);
    for (int i = 2; i < 8; i++) rd(3'(i), rst_tab[i]);
    $display("done: reset values");
    for (int i = 2; i < 8; i++) begin
      // fields kept nonzero
      d = $random(seed) | 32'h00000801;
      acc(1, 3'(i), d);
      rd(3'(i), d & ((i == 2 || i == 3 || i == 6) ? 32'h81fff800 : 32'h8000ffff));
    end
    root_n <= $random(seed);
    rm_n <= $random(seed);
    tree_v <= 1;
    @(posedge clock_i);
    tree_v <= 0;
    acc(1, 3'h1, 32'hffffffff);
    rd(3'h1, {18'h0, root_n, 2'h0, rm_n});
    $display("done: register access");
    acc(1, 3'h0, 32'h1);
    rd(3'h0, 32'h00000001);
    cfg_gap <= $random(seed);
    cfg_rhb <= 1;
    cfg_v <= 1;
    @(posedge clock_i);
    cfg_v <= 0;
    repeat (2) @(posedge clock_i);
    g = cfg_gap;
    chk({25'h0, rhb_o, gap_count_o}, {25'h0, 1'b1, g});
    acc(1, 3'h0, 32'h0);
    cfg_gap <= ~g;
    cfg_rhb <= 0;
    cfg_v <= 1;
    @(posedge clock_i);
    cfg_v <= 0;
    repeat (2) @(posedge clock_i);
    chk({25'h0, rhb_o, gap_count_o}, {25'h0, 1'b1, g});
    $display("done: config packet");
    for (int i = 0; i < 3; i++) begin
      a = (i == 2) ? 3'h7 : 3'(4 + i);
      n = 2 * i + 1;
      acc(1, a, {1'b0, 15'h0, 16'(n)});
      fire(i, 6000, 6000);
      acc(1, a, {1'b1, 15'h0, 16'(n)});
      // the timeout bit is registered one cycle after its timer expires
      fire(i, n + ((i == 0) ? 1 : 0), n + ((i == 0) ? 1 : 0));
    end
    #1;
    chk({31'h0, bias_bit_o}, 32'h1);
    @(posedge clock_i);
    bias_in <= 0;
    repeat (2) @(posedge clock_i);
    #1;
    chk({31'h0, bias_bit_o}, 32'h0);
    @(posedge clock_i);
    $display("done: fast timers");
    acc(1, 3'h2, {1'b0, 6'h0, 14'h2, 11'h0});
    fire(3, 6000, 6000);
    for (int i = 3; i < 7; i++) begin
      a = (i == 3) ? 3'h2 : (i == 4) ? 3'h3 : 3'h6;
      n = (i == 3) ? 2 : 1;
      acc(1, a, {1'b1, 6'h0, 14'(n), 11'h0});
      fire(i, (n - 1) * 2500 + 1, n * 2500 + 2);
    end
    $display("done: slow timers");
    finish_test;
  end
endmodule
